// File: rtl/fsr_ctrl.sv
// Controller-side framer and parser for format specification storage records.
// Assumes octet streams synchronous to CLK; the media side applies back-pressure.
`timescale 1ns/10ps
module fsr_ctrl (
	input  wire logic        CLK,          // 10 MHz clock
	input  wire logic        RST_B,        // Async reset, active low
	// Build side
	input  wire logic        TX_START,     // Pulse: begin a record
	input  wire logic [15:0] TX_LEN,       // Total length n+1 minus one
	input  wire logic        TX_LAST,      // Last field of storage
	input  wire logic [7:0]  TX_IDX,       // Copy index in set
	input  wire logic        TX_LVL3,      // Level 3 attributes present
	input  wire logic [7:0]  TX_GDATA,     // Group octet (set count..spec)
	input  wire logic        TX_GVALID,    // Group octet valid
	input  wire logic        TX_GEND,      // With octet: last of all groups
	output logic             TX_GREADY,    // Group octet taken
	output logic [7:0]       TX_DATA,      // Record octet out
	output logic             TX_VALID,     // Record octet valid
	input  wire logic        TX_READY,     // Media accepts octet
	output logic             TX_BUSY,      // Framing in progress
	// Parse side
	input  wire logic [7:0]  RX_DATA,      // Record octet in
	input  wire logic        RX_VALID,     // Record octet valid
	output logic             RX_READY,     // Parser accepts
	input  wire logic        RX_LVL3,      // Interpret attributes
	output logic [7:0]       RX_GDATA,     // Group octet out
	output logic             RX_GVALID,    // Group octet pulse
	output logic             RX_DONE,      // Pulse: record finished
	output logic             RX_LAST,      // Last-field flag seen
	output logic [7:0]       RX_IDX,       // Copy index seen
	output logic             RX_IGNORE,    // Index FF
	output logic             RX_ERR_IDX,   // Illegal index
	output logic             RX_ERR_CNT,   // Count mismatch
	output logic             RX_ERR_CRC    // CRC mismatch
);
	// ---------------------------------------------------------------
	// Build
	// ---------------------------------------------------------------
	fsr_pkg::fsr_st_t tst_q;
	logic [15:0] tcnt_q, tlen_q, tcrc_q, tspec_q;
	logic [4:0]  tgo_q;
	logic        tlast_q, tl3_q, tgend_q;
	logic [7:0]  tidx_q, tbyte_q;
	logic [7:0]  f_in;
	logic        f_in_v, f_in_r;
	logic [7:0]  tx_byte;
	wire         t_attr = (tgo_q >= fsr_pkg::G_ATTR_LO) && (tgo_q <= fsr_pkg::G_ATTR_HI);
	wire         t_grp  = (tst_q == fsr_pkg::S_GRP) || (tst_q == fsr_pkg::S_SPEC);
	// Last pad octet sits three before the end: CRC hi and lo follow it
	wire         t_pos  = (tcnt_q == tlen_q - 16'd3);
	wire [15:0]  tlen_m1 = tlen_q - 16'd1;

	// Zero the level 3 attribute octets when not in use
	assign tx_byte = (tst_q == fsr_pkg::S_GRP && t_attr && !tl3_q) ? 8'h00 : TX_GDATA;
	assign f_in = (tst_q == fsr_pkg::S_LEN)  ? (tcnt_q == 16'd0 ? tlen_m1[15:8] : tlen_m1[7:0]) :
	              (tst_q == fsr_pkg::S_FLAG) ? (tlast_q ? fsr_pkg::FLAG_LAST : 8'h00) :
	              (tst_q == fsr_pkg::S_IDX)  ? tidx_q :
	              t_grp ? tx_byte :
	              (tst_q == fsr_pkg::S_CRC)  ? (tcnt_q == tlen_q - 16'd2 ? tcrc_q[15:8] : tcrc_q[7:0]) :
	              8'h00;
	assign f_in_v    = (tst_q != fsr_pkg::S_IDLE) && (tst_q != fsr_pkg::S_DONE) &&
	                   (!t_grp || TX_GVALID);
	assign TX_GREADY = t_grp && f_in_r;
	assign TX_BUSY   = (tst_q != fsr_pkg::S_IDLE);
	wire   t_fire    = f_in_v && f_in_r;

	fsr_fifo #(.W(fsr_pkg::DW), .D(fsr_pkg::FIFO_DEPTH)) u_fifo (
		.CLK      (CLK),
		.RST_B    (RST_B),
		.in_data  (f_in),
		.in_valid (f_in_v),
		.in_ready (f_in_r),
		.out_data (TX_DATA),
		.out_valid(TX_VALID),
		.out_ready(TX_READY)
	);

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			tst_q <= fsr_pkg::S_IDLE;
			tcnt_q <= '0; tlen_q <= '0; tcrc_q <= fsr_pkg::CRC_INIT; tspec_q <= '0;
			tgo_q <= '0; tlast_q <= 1'b0; tl3_q <= 1'b0; tgend_q <= 1'b0;
			tidx_q <= '0; tbyte_q <= '0;
		end else begin
			if (tst_q == fsr_pkg::S_IDLE && TX_START) begin
				tst_q <= fsr_pkg::S_LEN;
				tlen_q <= TX_LEN + 16'd1;
				tlast_q <= TX_LAST;
				tidx_q <= TX_IDX;
				tl3_q <= TX_LVL3;
				tcnt_q <= '0;
				tgo_q <= '0;
				tgend_q <= 1'b0;
				tcrc_q <= fsr_pkg::CRC_INIT;
			end else if (tst_q == fsr_pkg::S_DONE) begin
				tst_q <= fsr_pkg::S_IDLE;
			end else if (t_fire) begin
				tcnt_q <= tcnt_q + 16'd1;
				if (tst_q != fsr_pkg::S_CRC)
					tcrc_q <= fsr_pkg::crc_step(tcrc_q, f_in);
				tbyte_q <= f_in;
				case (tst_q)
					fsr_pkg::S_LEN:  if (tcnt_q == 16'd1) tst_q <= fsr_pkg::S_FLAG;
					fsr_pkg::S_FLAG: tst_q <= fsr_pkg::S_IDX;
					fsr_pkg::S_IDX:  tst_q <= fsr_pkg::S_GRP;
					fsr_pkg::S_GRP: begin
						tgo_q <= tgo_q + 5'd1;
						if (tgo_q == fsr_pkg::G_SPEC_LEN)
							tspec_q[15:8] <= f_in;
						if (tgo_q == fsr_pkg::G_SPEC_LEN + 5'd1) begin
							tspec_q <= {tspec_q[15:8], f_in};
							tst_q <= fsr_pkg::S_SPEC;
						end
					end
					fsr_pkg::S_SPEC: begin
						tspec_q <= tspec_q - 16'd1;
						if (tspec_q == 16'd0) begin
							tgo_q <= '0;
							tst_q <= TX_GEND ? fsr_pkg::S_PAD : fsr_pkg::S_GRP;
						end
					end
					fsr_pkg::S_PAD:  if (t_pos) tst_q <= fsr_pkg::S_CRC;
					fsr_pkg::S_CRC:  if (tcnt_q == tlen_q - 16'd1) tst_q <= fsr_pkg::S_DONE;
					default:         tst_q <= fsr_pkg::S_IDLE;
				endcase
				if (tst_q == fsr_pkg::S_SPEC && tspec_q == 16'd0 && TX_GEND && t_pos)
					tst_q <= fsr_pkg::S_CRC;
			end
		end
	end

	// ---------------------------------------------------------------
	// Parse
	// ---------------------------------------------------------------
	fsr_pkg::fsr_st_t rst_q;
	logic [15:0] rcnt_q, rlen_q, rcrc_q, rspec_q, rrx_q;
	logic [4:0]  rgo_q;
	wire         r_fire = RX_VALID && RX_READY;
	wire         r_attr = (rgo_q >= fsr_pkg::G_ATTR_LO) && (rgo_q <= fsr_pkg::G_ATTR_HI);
	wire         r_bad  = (RX_DATA > fsr_pkg::IDX_MAX) && (RX_DATA != fsr_pkg::IDX_IGNORE);
	wire         r_tail = (rcnt_q == rlen_q - 16'd3);
	wire [15:0]  r_crcn = fsr_pkg::crc_step(rcrc_q, RX_DATA);

	assign RX_READY = 1'b1;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rst_q <= fsr_pkg::S_LEN;
			rcnt_q <= '0; rlen_q <= '0; rcrc_q <= fsr_pkg::CRC_INIT;
			rspec_q <= '0; rrx_q <= '0; rgo_q <= '0;
			RX_GDATA <= '0; RX_GVALID <= 1'b0; RX_DONE <= 1'b0;
			RX_LAST <= 1'b0; RX_IDX <= '0; RX_IGNORE <= 1'b0;
			RX_ERR_IDX <= 1'b0; RX_ERR_CNT <= 1'b0; RX_ERR_CRC <= 1'b0;
		end else begin
			RX_GVALID <= 1'b0;
			RX_DONE <= 1'b0;
			if (r_fire) begin
				rcnt_q <= rcnt_q + 16'd1;
				if (rst_q != fsr_pkg::S_CRC)
					rcrc_q <= r_crcn;
				case (rst_q)
					fsr_pkg::S_LEN: begin
						if (rcnt_q == 16'd0) begin
							rlen_q[15:8] <= RX_DATA;
							rcrc_q <= fsr_pkg::crc_step(fsr_pkg::CRC_INIT, RX_DATA);
							RX_ERR_IDX <= 1'b0; RX_ERR_CNT <= 1'b0; RX_ERR_CRC <= 1'b0;
						end else begin
							rlen_q <= {rlen_q[15:8], RX_DATA} + 16'd1;
							rst_q <= fsr_pkg::S_FLAG;
						end
					end
					fsr_pkg::S_FLAG: begin
						RX_LAST <= RX_DATA[fsr_pkg::FLAG_LAST_BIT];
						rst_q <= fsr_pkg::S_IDX;
					end
					fsr_pkg::S_IDX: begin
						RX_IDX <= RX_DATA;
						RX_IGNORE <= (RX_DATA == fsr_pkg::IDX_IGNORE);
						RX_ERR_IDX <= r_bad;
						rgo_q <= '0;
						rst_q <= fsr_pkg::S_GRP;
					end
					fsr_pkg::S_GRP: begin
						RX_GDATA <= (r_attr && !RX_LVL3) ? 8'h00 : RX_DATA;
						RX_GVALID <= 1'b1;
						rgo_q <= rgo_q + 5'd1;
						if (rgo_q == fsr_pkg::G_SPEC_LEN) rspec_q[15:8] <= RX_DATA;
						if (rgo_q == fsr_pkg::G_SPEC_LEN + 5'd1) begin
							rspec_q <= {rspec_q[15:8], RX_DATA};
							rst_q <= fsr_pkg::S_SPEC;
						end
						if (r_tail) rst_q <= fsr_pkg::S_CRC;
					end
					fsr_pkg::S_SPEC: begin
						RX_GDATA <= RX_DATA;
						RX_GVALID <= 1'b1;
						rspec_q <= rspec_q - 16'd1;
						if (rspec_q == 16'd0) begin
							rgo_q <= '0;
							rst_q <= fsr_pkg::S_PAD;
						end
						if (r_tail) rst_q <= fsr_pkg::S_CRC;
					end
					fsr_pkg::S_PAD: begin
						// Nonzero octet after a group starts another group
						if (RX_DATA != 8'h00) begin
							RX_GDATA <= RX_DATA;
							RX_GVALID <= 1'b1;
							rgo_q <= 5'd1;
							rst_q <= fsr_pkg::S_GRP;
						end
						if (r_tail) rst_q <= fsr_pkg::S_CRC;
					end
					fsr_pkg::S_CRC: begin
						rrx_q[15:8] <= RX_DATA;
						if (rcnt_q == rlen_q - 16'd1) begin
							RX_ERR_CRC <= ({rrx_q[15:8], RX_DATA} != rcrc_q);
							RX_ERR_CNT <= (rspec_q != 16'd0) && (rgo_q != 5'd0);
							RX_DONE <= 1'b1;
							rcnt_q <= '0;
							rst_q <= fsr_pkg::S_LEN;
						end
					end
					default: rst_q <= fsr_pkg::S_LEN;
				endcase
				if (rst_q == fsr_pkg::S_LEN && rcnt_q != 16'd0 &&
				    {rlen_q[15:8], RX_DATA} < 16'h0003) begin
					RX_ERR_CNT <= 1'b1;
				end
			end
		end
	end
endmodule : fsr_ctrl

// File: rtl/fsr_fifo.sv
// Parameterised octet FIFO with valid/ready on both sides.
// Assumes a single clock and an active-low asynchronous reset.
`timescale 1ns/10ps
module fsr_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input  wire logic         CLK,     // Clock
	input  wire logic         RST_B,   // Reset, active low
	input  wire logic [W-1:0] in_data, // Write data
	input  wire logic         in_valid,// Write valid
	output logic              in_ready,// Not full
	output logic [W-1:0]      out_data,// Read data
	output logic              out_valid,// Not empty
	input  wire logic         out_ready // Read accept
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem_q [D];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0]   cnt_q;
	wire           wr = in_valid & in_ready;
	wire           rd = out_valid & out_ready;

	assign in_ready  = (cnt_q != (AW+1)'(D));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rp_q];

	always_ff @(posedge CLK) begin
		if (wr) mem_q[wp_q] <= in_data;
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (wr) wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
			if (rd) rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
		end
	end
endmodule : fsr_fifo

// File: rtl/fsr_pkg.sv
// Constants for the format specification storage record framer and parser.
// Assumes one 10 MHz clock and octet streams in that clock domain.
// Function
// - Octets 0-1 hold the count of octets that follow, record length minus one.
// - Flag octet 2 bit 7 marks the last field; other flag bits zero.
// - Octet 3 is copy index 00/01/02 or FF ignore; 03-FE illegal.
// - Octets 4-5 hold the total number of sets.
// - Octets 6-7 hold the index of this set.
// - Octet 8 partition, 9 alias, A-D data block size.
// - Octet E bits 7/6/5 give equal, multiple, non-multiple block relation.
// - Octet E bit 0 set when the controller interleaves; bits 4-1 undefined.
// - Octets F,10,11 interleave factors; octet 12 alternate cylinders.
// - Octet 13 holds spare sectors per track.
// - Octets 14-17 hold partition starting cylinder.
// - Octets 18-1B hold partition cylinder count.
// - Octets 1C-1D spec length minus one; spec follows from 1E.
// - Each further partition appends another group from set count to spec end.
// - Without level 3, octets 8-1B written zero and ignored on parse.
// - Last two octets are CRC-16 x16+x15+x2+1 over the data area.
package fsr_pkg;
	localparam int DW          = 8;
	localparam int FIFO_DEPTH  = 16;
	localparam int GRP_LEN     = 26;          // Octets 4..1D of a group
	localparam logic [7:0] FLAG_LAST = 8'h80;
	localparam int  FLAG_LAST_BIT     = 7;
	localparam logic [7:0] IDX_IGNORE = 8'hff;
	localparam logic [7:0] IDX_MAX    = 8'h02;
	localparam logic [15:0] CRC_POLY  = 16'h8005;
	localparam logic [15:0] CRC_INIT  = 16'h0000;
	// Group-relative offsets (group starts at record octet 4)
	localparam logic [4:0] G_ATTR_LO  = 5'h04;   // Record octet 8
	localparam logic [4:0] G_ATTR_HI  = 5'h17;   // Record octet 1B
	localparam logic [4:0] G_SPEC_LEN = 5'h18;   // Record octets 1C-1D
	typedef enum { S_IDLE, S_LEN, S_FLAG, S_IDX, S_GRP, S_SPEC, S_PAD, S_CRC, S_DONE } fsr_st_t;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = DW - 1; i >= 0; i--) begin
			r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
		end
		return r;
	endfunction : crc_step
endpackage : fsr_pkg

// File: verif/format_spec_storage_record_tb.sv
// Self-checking bench for fsr_ctrl with the media model.
// Assumes one 10 MHz clock.
`timescale 1ns/10ps
module format_spec_storage_record_tb;
	logic CLK = 0, RST_B = 0, TX_START = 0, TX_LAST = 0, TX_LVL3 = 0;
	logic TX_GVALID = 0, TX_GEND = 0, RX_LVL3 = 0, slow = 0, clr = 0, play = 0;
	logic [15:0] TX_LEN = 16'h0000;
	logic [7:0] TX_IDX = 8'h00, TX_GDATA = 8'h00, bad_val = 8'h00, RX_DATA, TX_DATA;
	logic [7:0] RX_GDATA, RX_IDX, e [0:35], rg [0:63];
	logic [6:0] bad_at = 7'h7f, cnt;
	logic TX_GREADY, TX_VALID, TX_READY, TX_BUSY, RX_VALID, RX_READY, RX_GVALID, RX_DONE;
	logic RX_LAST, RX_IGNORE, RX_ERR_IDX, RX_ERR_CNT, RX_ERR_CRC;
	int bad_count = 0, n_tests = 0, nr;
	logic [7:0] hd [0:3] = '{8'h01, 8'h02, 8'h00, 8'h01};
	logic [7:0] tl [0:3] = '{8'h00, 8'h01, 8'ha5, 8'h5a};
	fsr_ctrl uut (.*);
	fsr_media med (.CLK(CLK), .RST_B(RST_B), .tx_data(TX_DATA), .tx_valid(TX_VALID),
		.tx_ready(TX_READY), .slow(slow), .clr(clr), .play(play), .bad_at(bad_at),
		.bad_val(bad_val), .rx_data(RX_DATA), .rx_valid(RX_VALID), .cnt(cnt));
	always #50 CLK = ~CLK;
	task summarize;
		if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : summarize
	task chk(input string w, input logic [15:0] s, input logic [15:0] x);
		n_tests++;
		if (s !== x) begin
			bad_count++;
			$display("BAD %s exp %h seen %h", w, x, s);
		end
	endtask : chk
	task cyc;
		@(posedge CLK);
		#1;
	endtask : cyc
	task tmo(input int t);
		if (t >= 300) begin
			bad_count++;
			summarize;
		end
	endtask : tmo
	function logic [7:0] gv(input int k);
		return k < 4 ? hd[k] : (k > 23 ? tl[k-24] : 8'h10 + k[7:0]);
	endfunction : gv
	task build(input logic l3, input logic last, input logic [7:0] idx, input logic sl);
		int t, wt;
		logic [15:0] c;
		wt = 0;
		c = fsr_pkg::CRC_INIT;
		e[0:3] = '{8'h00, 8'h23, {last, 7'h00}, idx};
		for (int k = 0; k < 28; k++) e[4+k] = (k > 3 && k < 24 && !l3) ? 8'h00 : gv(k);
		e[32] = 8'h00;
		e[33] = 8'h00;
		for (int i = 0; i < 272; i++)
			c = (c[15] ^ e[i/8][7-i%8]) ? ((c << 1) ^ fsr_pkg::CRC_POLY) : (c << 1);
		{e[34], e[35]} = c;
		slow = sl;
		clr = 1;
		cyc;
		clr = 0;
		{TX_START, TX_LEN, TX_LAST, TX_IDX, TX_LVL3} = {1'b1, 16'h0023, last, idx, l3};
		cyc;
		TX_START = 0;
		for (int k = 0; k < 28; k++) begin
			{TX_GDATA, TX_GVALID, TX_GEND} = {gv(k), 1'b1, k == 27};
			for (t = 0; !TX_GREADY && t < 300; t++) cyc;
			tmo(t);
			wt += t;
			cyc;
		end
		{TX_GVALID, TX_GEND} = 2'b00;
		for (t = 0; (TX_BUSY || cnt != 7'd36) && t < 300; t++) cyc;
		tmo(t);
		chk("refused", wt > 4, sl);
		chk("length", cnt, 36);
		for (int i = 0; i < 36; i++) chk("octet", med.mem_q[i], e[i]);
	endtask : build
	task replay(input logic l3, input logic [6:0] at, input logic [7:0] v);
		int t;
		{RX_LVL3, bad_at, bad_val, play} = {l3, at, v, 1'b1};
		nr = 0;
		for (t = 0; !RX_DONE && t < 300; t++) begin
			cyc;
			if (RX_GVALID === 1'b1) rg[nr++] = RX_GDATA;
		end
		tmo(t);
		play = 0;
		cyc;
	endtask : replay
	task s_clean;
		build(0, 1, 8'h01, 1);
		replay(1, 7'h7f, 8'h00);
		chk("errs", {RX_ERR_CRC, RX_ERR_CNT, RX_ERR_IDX, RX_IGNORE}, 0);
		chk("last", RX_LAST, 1);
		chk("idx", RX_IDX, 8'h01);
		chk("groups", nr, 28);
		for (int k = 0; k < 28; k++) chk("group", rg[k], e[4+k]);
	endtask : s_clean
	task s_ignore;
		build(1, 0, 8'hff, 0);
		replay(0, 7'h7f, 8'h00);
		chk("ign", {RX_IGNORE, RX_LAST, RX_ERR_CRC}, 3'b100);
		chk("attr zero", rg[4], 8'h00);
		chk("spec", rg[26], 8'ha5);
	endtask : s_ignore
	task s_crc;
		replay(1, 7'd35, ~e[35]);
		chk("crc err", RX_ERR_CRC, 1);
		chk("attr", rg[4], 8'h14);
	endtask : s_crc
	task s_idx;
		logic [7:0] v [0:2] = '{8'h03, 8'hfe, 8'h02};
		for (int i = 0; i < 3; i++) begin
			replay(1, 7'd3, v[i]);
			chk("idx err", RX_ERR_IDX, v[i] != 8'h02);
			chk("idx seen", RX_IDX, v[i]);
		end
	endtask : s_idx
	initial begin
		repeat (4) @(posedge CLK);
		#1;
		RST_B = 1;
		cyc;
		s_clean;
		s_ignore;
		s_crc;
		s_idx;
		summarize;
	end
endmodule : format_spec_storage_record_tb

// File: verif/fsr_ctrl_asserts.sv
// Checker for the record framer and parser ports.
// Assumes it is bound to fsr_ctrl.
`timescale 1ns/10ps
module fsr_ctrl_asserts (
	input wire logic       CLK,        // Clock
	input wire logic       RST_B,      // Reset, active low
	input wire logic       TX_START,   // Start
	input wire logic       TX_BUSY,    // Busy
	input wire logic       TX_VALID,   // Octet valid
	input wire logic       TX_READY,   // Media ready
	input wire logic [7:0] TX_DATA,    // Octet
	input wire logic       TX_GREADY,  // Group taken
	input wire logic       RX_READY,   // Parser ready
	input wire logic [7:0] RX_IDX,     // Index seen
	input wire logic       RX_IGNORE,  // Index FF
	input wire logic       RX_ERR_IDX  // Illegal index
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	property p_hold; TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA); endproperty
	a_hold: assert property (p_hold) else $error("octet dropped under stall");
	property p_busy; TX_START && !TX_BUSY |=> TX_BUSY; endproperty
	a_busy: assert property (p_busy) else $error("start not taken");
	property p_idle; !TX_BUSY && !TX_START |=> !TX_BUSY; endproperty
	a_idle: assert property (p_idle) else $error("busy without start");
	property p_first; $rose(TX_BUSY) |-> ##1 TX_VALID; endproperty
	a_first: assert property (p_first) else $error("first octet late");
	property p_gr; TX_GREADY |-> TX_BUSY; endproperty
	a_gr: assert property (p_gr) else $error("group taken while idle");
	property p_ign; RX_IGNORE |-> RX_IDX == 8'hff; endproperty
	a_ign: assert property (p_ign) else $error("ignore flag wrong");
	property p_ill; RX_ERR_IDX |-> RX_IDX > 8'h02 && RX_IDX != 8'hff; endproperty
	a_ill: assert property (p_ill) else $error("index error wrong");
	property p_rdy; RX_READY; endproperty
	a_rdy: assert property (p_rdy) else $error("parser refused");
	c_stall: cover property (TX_VALID && !TX_READY);
	c_ign: cover property (RX_IGNORE);
	c_ill: cover property (RX_ERR_IDX);
endmodule : fsr_ctrl_asserts
bind fsr_ctrl fsr_ctrl_asserts chk (.CLK(CLK), .RST_B(RST_B), .TX_START(TX_START),
	.TX_BUSY(TX_BUSY), .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_DATA(TX_DATA),
	.TX_GREADY(TX_GREADY), .RX_READY(RX_READY), .RX_IDX(RX_IDX), .RX_IGNORE(RX_IGNORE),
	.RX_ERR_IDX(RX_ERR_IDX));

// File: verif/fsr_media.sv
// Model of the media storage area: stores written octets, replays them.
// Assumes one clock; replay may spoil one octet on request.
`timescale 1ns/10ps
module fsr_media (
	input  wire logic       CLK,      // Clock
	input  wire logic       RST_B,    // Reset, active low
	input  wire logic [7:0] tx_data,  // Octet in
	input  wire logic       tx_valid, // In valid
	output logic            tx_ready, // In accept
	input  wire logic       slow,     // Stall mode
	input  wire logic       clr,      // Empty area
	input  wire logic       play,     // Replay
	input  wire logic [6:0] bad_at,   // Spoil position
	input  wire logic [7:0] bad_val,  // Spoil value
	output logic [7:0]      rx_data,  // Octet out
	output logic            rx_valid, // Out valid
	output logic [6:0]      cnt       // Octets stored
);
	logic [7:0] mem_q [0:63];
	logic [6:0] rd_q;
	logic [6:0] cyc_q;
	logic [7:0] last_q;
	wire logic [7:0] cur = (rd_q == bad_at) ? bad_val : mem_q[rd_q[5:0]];
	assign tx_ready = !slow || (cyc_q >= 7'd30 && cyc_q[0]);
	assign rx_valid = play && (rd_q < cnt);
	// Idle line shows no stale octet
	assign rx_data = rx_valid ? cur : ~last_q;
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			cnt <= 7'h00;
			rd_q <= 7'h00;
			cyc_q <= 7'h00;
			last_q <= 8'h00;
		end else begin
			if (tx_valid && tx_ready) begin
				mem_q[cnt[5:0]] <= tx_data;
				cnt <= cnt + 7'h01;
			end
			if (tx_valid && cyc_q != 7'h7f)
				cyc_q <= cyc_q + 7'h01;
			if (clr) begin
				cnt <= 7'h00;
				cyc_q <= 7'h00;
			end
			rd_q <= rx_valid ? rd_q + 7'h01 : (play ? rd_q : 7'h00);
			if (rx_valid)
				last_q <= cur;
		end
	end
endmodule : fsr_media
